// ===== design/mmc_misc_regs.sv
/*
 * mmc_misc_regs: miscellaneous MAC control registers on Avalon-MM.
 * assumes: master holds each request until waitrequest low; DMA idle inputs synchronous.
 */
// Added by the designer: register access over Avalon-MM and the placing of the registers.
// Function
// - free-run set: keep running in debug halt, soft bit ignored
// - free-run set: all activity continues while debug halt asserted
// - free and soft clear: halt immediately on debug halt
// - free clear, soft set: finish current operation, then halt
// - no transmit start until programmed count of 64-byte cells present
// - short packets start once the whole packet is in the FIFO
// - capability word reads 3, 3, 2, 2 from the top byte down
// - writing one to reset bit requests a full MAC reset
// - reset waits until receive and transmit DMA are idle
// - reset bit reads one while pending, zero once done
`timescale 1ns/1ps
module mmc_misc_regs
	import mmc_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [3:0]       address,
	input  wire logic             read,
	input  wire logic             write,
	input  wire logic [31:0]      writedata,
	input  wire logic [3:0]       byteenable,
	output logic [31:0]           readdata,
	output logic                  waitrequest,
	output logic [1:0]            response,
	input  wire logic             debugHalt,
	input  wire logic             macBusy,
	input  wire logic             rxDmaIdle,
	input  wire logic             txDmaIdle,
	input  wire logic [CNT_W-1:0] txCellCount,
	input  wire logic             txPktComplete,
	input  wire logic             txPktDone,
	output logic                  stopReq,
	output logic                  txStart,
	output logic                  txActive,
	output logic                  macSoftReset
);
	import mmc_pkg::*;

	logic [1:0]      suspend_q;
	logic [1:0]      startCount_q;
	mmc_srst_state_t srst_q;
	logic            ack_q;
	logic [31:0]     readdata_q;
	logic [1:0]      response_q;
	logic            mapped;
	logic            req;
	logic [31:0]     capWord;

	// ------------------------------------------------------------
	// bus handshake: one wait cycle, then answer
	// ------------------------------------------------------------
	assign req         = read || write;
	assign waitrequest = req && !ack_q;
	assign readdata    = readdata_q;
	assign response    = response_q;
	assign mapped      = (address == OFF_DEBUG_SUSPEND) || (address == OFF_TX_START_THRESH) ||
		(address == OFF_CAPABILITY) || (address == OFF_SW_RESET);

	// fixed capability word
	assign capWord = (32'(TX_CELL_CAPACITY) << CAP_TX_LSB) | (32'(RX_CELL_CAPACITY) << CAP_RX_LSB) |
		(32'(ADDR_KIND_CODE) << CAP_ADDR_LSB) | (32'(MAC_BUILD_VALUE) << CAP_BUILD_LSB);

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			ack_q <= 1'b0;
		else
			ack_q <= req && !ack_q;
	end

	// ------------------------------------------------------------
	// read data, latched in the wait cycle
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			readdata_q <= 32'h0000_0000;
			response_q <= 2'h0;
		end
		else if (req && !ack_q)
		begin
			response_q <= mapped ? 2'h0 : 2'h3;
			readdata_q <= 32'h0000_0000;
			if (read)
			begin
				case (address)
					OFF_DEBUG_SUSPEND:   readdata_q <= {30'h0, suspend_q};
					OFF_TX_START_THRESH: readdata_q <= {30'h0, startCount_q};
					OFF_CAPABILITY:      readdata_q <= capWord;
					OFF_SW_RESET:        readdata_q <= {31'h0, srst_q != SR_IDLE};
					default:             readdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// suspend control register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			suspend_q <= SUSPEND_RESET;
		else if (macSoftReset)
			suspend_q <= SUSPEND_RESET;
		else if (write && ack_q && address == OFF_DEBUG_SUSPEND && byteenable[0])
			suspend_q <= writedata[1:0];
	end

	// ------------------------------------------------------------
	// transmit start threshold register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			startCount_q <= TX_THRESH_RESET;
		else if (macSoftReset)
			startCount_q <= TX_THRESH_RESET;
		else if (write && ack_q && address == OFF_TX_START_THRESH && byteenable[0])
			startCount_q <= writedata[1:0];
	end

	// ------------------------------------------------------------
	// software reset sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			srst_q <= SR_IDLE;
		else
		begin
			case (srst_q)
				SR_IDLE:
					if (write && ack_q && address == OFF_SW_RESET && byteenable[0] && writedata[SWRST_BIT])
						srst_q <= SR_WAIT;
				SR_WAIT:
					if (rxDmaIdle && txDmaIdle)
						srst_q <= SR_FIRE;
				SR_FIRE: srst_q <= SR_IDLE;
				default: srst_q <= SR_IDLE;
			endcase
		end
	end

	// one-cycle reset pulse to the MAC logic
	assign macSoftReset = (srst_q == SR_FIRE);

	// ------------------------------------------------------------
	// suspend and transmit start
	// ------------------------------------------------------------
	mmc_suspend_ctl uSuspend (
		.clock    (clock),
		.nrst     (nrst),
		.debugHalt(debugHalt),
		.freeRun  (suspend_q[FREE_BIT]),
		.softStop (suspend_q[SOFT_BIT]),
		.opBusy   (macBusy || txActive),
		.stopReq  (stopReq)
	);

	mmc_tx_start #(.CNT_W(CNT_W)) uTxStart (
		.clock      (clock),
		.nrst       (nrst),
		.startCount (startCount_q),
		.cellCount  (txCellCount),
		.pktComplete(txPktComplete),
		.pktDone    (txPktDone || macSoftReset),
		.stopReq    (stopReq),
		.txStart    (txStart),
		.txActive   (txActive)
	);

endmodule : mmc_misc_regs

// ===== design/mmc_pkg.sv
/*
 * mmc_pkg: register map, field layout, reset values and state encodings
 * for the miscellaneous MAC control registers.
 * assumes: 32-bit Avalon-MM word addressing by byte address.
 */
package mmc_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [3:0] OFF_DEBUG_SUSPEND  = 4'h0;
	localparam logic [3:0] OFF_TX_START_THRESH = 4'h4;
	localparam logic [3:0] OFF_CAPABILITY     = 4'h8;
	localparam logic [3:0] OFF_SW_RESET       = 4'hc;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FREE_BIT     = 0;
	localparam int SOFT_BIT     = 1;
	localparam int SWRST_BIT    = 0;
	localparam int CAP_TX_LSB   = 24;
	localparam int CAP_RX_LSB   = 16;
	localparam int CAP_ADDR_LSB = 8;
	localparam int CAP_BUILD_LSB = 0;

	// ------------------------------------------------------------
	// reset and constant values
	// ------------------------------------------------------------
	localparam logic [1:0] TX_THRESH_RESET  = 2'h2;
	localparam logic [7:0] TX_CELL_CAPACITY = 8'h03;
	localparam logic [7:0] RX_CELL_CAPACITY = 8'h03;
	localparam logic [7:0] ADDR_KIND_CODE   = 8'h02;
	localparam logic [7:0] MAC_BUILD_VALUE  = 8'h02;
	localparam int         CELL_BYTES       = 64;
	localparam logic [1:0] SUSPEND_RESET    = 2'h0;

	// ------------------------------------------------------------
	// state encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SR_IDLE  = 3'b001,
		SR_WAIT  = 3'b010,
		SR_FIRE  = 3'b100
	} mmc_srst_state_t;

	typedef enum logic [2:0] {
		TX_HOLD  = 3'b001,
		TX_SEND  = 3'b010,
		TX_DONE  = 3'b100
	} mmc_tx_state_t;

endpackage : mmc_pkg

// ===== design/mmc_suspend_ctl.sv
/*
 * mmc_suspend_ctl: turns the debug-halt input and the two suspend bits
 * into stop requests for the MAC.
 * assumes: debugHalt is synchronous to clock; opBusy marks an operation.
 */
`timescale 1ns/1ps
module mmc_suspend_ctl
	import mmc_pkg::*;
(
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic debugHalt,
	input  wire logic freeRun,
	input  wire logic softStop,
	input  wire logic opBusy,
	output logic      stopReq
);

	logic stop_q;

	// ------------------------------------------------------------
	// stop request: free wins, soft waits for idle
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			stop_q <= 1'b0;
		else if (!debugHalt || freeRun)
			stop_q <= 1'b0;
		else if (!softStop)
			stop_q <= 1'b1;
		else if (!opBusy || stop_q)
			stop_q <= 1'b1;
	end

	// hard stop asserts at once, soft stop only once latched
	assign stopReq = debugHalt && !freeRun && (!softStop || stop_q);

endmodule : mmc_suspend_ctl

// ===== design/mmc_tx_start.sv
/*
 * mmc_tx_start: decides when a packet held in the transmit FIFO may start.
 * assumes: cellCount counts whole 64-byte cells of the head packet,
 * pktComplete marks that the whole head packet is present.
 */
`timescale 1ns/1ps
module mmc_tx_start
	import mmc_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [1:0]       startCount,
	input  wire logic [CNT_W-1:0] cellCount,
	input  wire logic             pktComplete,
	input  wire logic             pktDone,
	input  wire logic             stopReq,
	output logic                  txStart,
	output logic                  txActive
);

	mmc_tx_state_t state_q;
	logic          ready;

	// threshold met or whole short packet present
	assign ready = (cellCount >= CNT_W'(startCount)) || pktComplete;

	// ------------------------------------------------------------
	// start sequencing
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			state_q <= TX_HOLD;
		else
		begin
			case (state_q)
				TX_HOLD: if (ready && !stopReq) state_q <= TX_SEND;
				TX_SEND: state_q <= TX_DONE;
				TX_DONE: if (pktDone) state_q <= TX_HOLD;
				default: state_q <= TX_HOLD;
			endcase
		end
	end

	assign txStart  = (state_q == TX_SEND);
	assign txActive = (state_q != TX_HOLD);

endmodule : mmc_tx_start

// ===== tb/mmc_misc_regs_chk.sv
/* mmc_misc_regs_chk: port-level assertions for the misc MAC registers.
   assumes: bound into mmc_misc_regs; writes always carry all byte lanes. */
`timescale 1ns/1ps
module mmc_misc_regs_chk
	import mmc_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	input wire logic             clock,
	input wire logic             nrst,
	input wire logic [3:0]       address,
	input wire logic             read,
	input wire logic             write,
	input wire logic [31:0]      writedata,
	input wire logic [31:0]      readdata,
	input wire logic             waitrequest,
	input wire logic             debugHalt,
	input wire logic             macBusy,
	input wire logic             rxDmaIdle,
	input wire logic             txDmaIdle,
	input wire logic [CNT_W-1:0] txCellCount,
	input wire logic             txPktComplete,
	input wire logic             stopReq,
	input wire logic             txStart,
	input wire logic             txActive,
	input wire logic             macSoftReset
);
	logic [1:0] susp_q;
	logic [1:0] thr_q;
	logic       wrOk;
	logic       idle;
	assign wrOk = write && !waitrequest;
	assign idle = rxDmaIdle && txDmaIdle;
	// mirror of the suspend field
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
			susp_q <= SUSPEND_RESET;
		else if (macSoftReset)
			susp_q <= SUSPEND_RESET;
		else if (wrOk && address == OFF_DEBUG_SUSPEND)
			susp_q <= writedata[1:0];
	// mirror of the start threshold
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
			thr_q <= TX_THRESH_RESET;
		else if (macSoftReset)
			thr_q <= TX_THRESH_RESET;
		else if (wrOk && address == OFF_TX_START_THRESH)
			thr_q <= writedata[1:0];
	// ----
	// assertions
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	chk_free_runs: assert property (susp_q[FREE_BIT] |-> !stopReq)
		else $error("stop raised in free run");
	chk_halt_now: assert property (susp_q == 2'b00 |-> stopReq == debugHalt)
		else $error("hard stop not immediate");
	chk_soft_waits: assert property (susp_q == 2'b10 && $rose(stopReq) |-> $past(debugHalt && !macBusy && !txActive))
		else $error("soft stop during operation");
	chk_soft_drop: assert property (susp_q == 2'b10 && !debugHalt && !wrOk && !macSoftReset |=> !stopReq)
		else $error("soft stop without halt");
	chk_start_cause: assert property (txStart |-> $past((txCellCount >= thr_q || txPktComplete) && !stopReq))
		else $error("transmit start too early");
	chk_cap_word: assert property (read && !waitrequest && address == OFF_CAPABILITY |-> readdata == 32'h03030202)
		else $error("capability word wrong");
	chk_reset_idle: assert property (macSoftReset |-> $past(idle) ##1 !macSoftReset)
		else $error("reset while dma busy");
	chk_reset_fires: assert property (wrOk && address == OFF_SW_RESET && writedata[SWRST_BIT] && idle ##1 idle[*2]
		|-> ##[0:2] macSoftReset)
		else $error("reset request lost");
	// main scenarios seen
	cov_reset: cover property (macSoftReset);
	cov_start: cover property (txStart);
	cov_soft: cover property (susp_q == 2'b10 && stopReq);
endmodule : mmc_misc_regs_chk

bind mmc_misc_regs mmc_misc_regs_chk #(.CNT_W(CNT_W)) u_chk (
	.clock        (clock),
	.nrst         (nrst),
	.address      (address),
	.read         (read),
	.write        (write),
	.writedata    (writedata),
	.readdata     (readdata),
	.waitrequest  (waitrequest),
	.debugHalt    (debugHalt),
	.macBusy      (macBusy),
	.rxDmaIdle    (rxDmaIdle),
	.txDmaIdle    (txDmaIdle),
	.txCellCount  (txCellCount),
	.txPktComplete(txPktComplete),
	.stopReq      (stopReq),
	.txStart      (txStart),
	.txActive     (txActive),
	.macSoftReset (macSoftReset)
);

// ===== tb/tb_mac_misc_control_regs.sv
/* tb_mac_misc_control_regs: self-checking bench for the misc MAC registers.
   assumes: package, design and checker compiled before it. */
`timescale 1ns/1ps
module tb_mac_misc_control_regs;
	import mmc_pkg::*;
	logic        clock = 0, nrst = 0, read = 0, write = 0, debugHalt = 0, macBusy = 0;
	logic        rxDmaIdle = 1, txDmaIdle = 1, txPktComplete = 0, txPktDone = 0;
	logic        waitrequest, stopReq, txStart, txActive, macSoftReset;
	logic [1:0]  response, rsp;
	logic [3:0]  address = 0, byteenable = 4'hf;
	logic [7:0]  txCellCount = 0;
	logic [15:0] rnd = 16'h0ba5;
	logic [31:0] writedata = 0, readdata, q;
	int          miscompares = 0, n_compared = 0, cyc = 0, exp;
	always #2.5 clock = ~clock;
	mmc_misc_regs #(.CNT_W(8)) dut (
		.clock        (clock),
		.nrst         (nrst),
		.address      (address),
		.read         (read),
		.write        (write),
		.writedata    (writedata),
		.byteenable   (byteenable),
		.readdata     (readdata),
		.waitrequest  (waitrequest),
		.response     (response),
		.debugHalt    (debugHalt),
		.macBusy      (macBusy),
		.rxDmaIdle    (rxDmaIdle),
		.txDmaIdle    (txDmaIdle),
		.txCellCount  (txCellCount),
		.txPktComplete(txPktComplete),
		.txPktDone    (txPktDone),
		.stopReq      (stopReq),
		.txStart      (txStart),
		.txActive     (txActive),
		.macSoftReset (macSoftReset)
	);
	// ----
	// helpers
	// ----
	function automatic logic [15:0] lf(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lf
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
		n_compared++;
		if (got !== ex)
		begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", nm, ex, got);
		end
	endtask : chk
	// one Avalon access, held until waitrequest is sampled low at a rising edge
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		// answer edge: data taken here, then the request is dropped
		q = readdata;
		rsp = response;
		read <= 0;
		write <= 0;
	endtask : acc
	task automatic rst_chk;
		int regm[4] = '{0, 2, 32'h03030202, 0};
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b0, 4'(4 * i), 0);
			chk("reg", q, regm[i]);
		end
	endtask : rst_chk
	task automatic final_report;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	// hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	// ----
	// main sequence
	// ----
	initial
	begin
		repeat (4) @(posedge clock);
		nrst <= 1;
		acc(1'b1, OFF_CAPABILITY, 0);
		rst_chk();
		acc(1'b0, 4'h1, 0);
		chk("resp", rsp, 3);
		chk("unmapped", q, 0);
		$display("test registers done");
		// every suspend mode, busy then idle in modes 2 and 3 (idle only in modes 0 and 1)
		for (int m = 0; m < 4; m++)
		begin
			acc(1'b1, OFF_DEBUG_SUSPEND, m);
			macBusy <= m[1];
			debugHalt <= 1;
			repeat (2) @(negedge clock);
			chk("stop", stopReq, m == 0);
			@(posedge clock);
			macBusy <= 0;
			repeat (2) @(negedge clock);
			chk("stop", stopReq, !m[0]);
			@(posedge clock);
			debugHalt <= 0;
			acc(1'b0, OFF_DEBUG_SUSPEND, 0);
			chk("susp", q, m);
		end
		$display("test suspend done");
		// random cell counts against both thresholds
		acc(1'b1, OFF_DEBUG_SUSPEND, 1);
		for (int i = 0; i < 24; i++)
		begin
			rnd = lf(rnd);
			exp = 2 + rnd[0];
			acc(1'b1, OFF_TX_START_THRESH, exp);
			txCellCount <= 8'(rnd[2:1]);
			txPktComplete <= rnd[4];
			repeat (2) @(negedge clock);
			chk("start", txStart, rnd[2:1] >= exp || rnd[4]);
			chk("active", txActive, rnd[2:1] >= exp || rnd[4]);
			@(posedge clock);
			txCellCount <= 0;
			txPktComplete <= 0;
			txPktDone <= 1;
			@(posedge clock);
			txPktDone <= 0;
		end
		$display("test start done");
		// soft reset held off by each dma in turn
		acc(1'b1, OFF_TX_START_THRESH, 3);
		acc(1'b1, OFF_DEBUG_SUSPEND, 2);
		rxDmaIdle <= 0;
		acc(1'b1, OFF_SW_RESET, 1);
		for (int k = 0; k < 2; k++)
		begin
			acc(1'b0, OFF_SW_RESET, 0);
			chk("pend", q, 1);
			rxDmaIdle <= 1;
			txDmaIdle <= k[0];
		end
		exp = 0;
		repeat (8)
		begin
			@(negedge clock);
			if (macSoftReset === 1'b1)
				exp++;
		end
		chk("pulse", exp, 1);
		rst_chk();
		// request with both dma idle: pulse follows after the one SR_WAIT cycle
		acc(1'b1, OFF_SW_RESET, 1);
		exp = 0;
		repeat (4)
		begin
			@(negedge clock);
			if (macSoftReset === 1'b1)
				exp++;
		end
		chk("pulse", exp, 1);
		acc(1'b0, OFF_SW_RESET, 0);
		chk("done", q, 0);
		$display("test soft reset done");
		final_report();
	end
endmodule : tb_mac_misc_control_regs
